// ==== rtl/swdt_pkg.sv ====
// Package for the system watchdog timer: offsets, fields, resets, state
package swdt_pkg;

	localparam logic [11:0] ADDR_LOAD      = 12'h000;
	localparam logic [11:0] ADDR_COUNT     = 12'h004;
	localparam logic [11:0] ADDR_CONTROL   = 12'h008;
	localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h00c;
	localparam logic [11:0] ADDR_RAW_STAT  = 12'h010;
	localparam logic [11:0] ADDR_MASK_STAT = 12'h014;
	localparam logic [11:0] ADDR_PROTECT   = 12'hc00;
	localparam logic [11:0] ADDR_IRQ_MASK  = 12'h018;

	localparam logic [31:0] LOAD_RESET     = 32'h0fff_ffff;
	localparam logic [31:0] UNLOCK_KEY     = 32'h1acc_e551;
	localparam int          IRQ_EN_BIT     = 0;
	localparam int          REBOOT_EN_BIT  = 1;
	localparam int          TICK_DIV_BITS  = 10;
	localparam logic [9:0]  TICK_DIV_RESET = 10'h000;

	// Tick figure: slow counting rate and bus clock rate
	localparam int          SLOW_HZ        = 32768;
	localparam int          MCLK_HZ        = 25000000;
	// Cycles per tick, rounded down
	localparam logic [9:0]  TICK_CYCLES    = 10'(MCLK_HZ / SLOW_HZ);

	typedef enum logic [0:0] {
		WD_IDLE = 1'b0,
		WD_RUN  = 1'b1
	} swdt_mode_e;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} swdt_req_s;

	typedef struct packed {
		swdt_mode_e  mode;
		logic [31:0] load;
		logic [31:0] count;
		logic        irq_en;
		logic        reboot_en;
		logic        irq_mask;
		logic        raw_irq;
		logic        locked;
		logic [9:0]  div;
		logic [31:0] rdata;
		logic        irq;
		logic        reboot;
	} swdt_state_s;

endpackage : swdt_pkg

// ==== rtl/swdt_top.sv ====
// System watchdog timer: down counter, interrupt, reboot output, write lock
//
// How it works
// - 32-bit counter decrements once per tick at about 32.768 kHz.
// - Interrupt period is load value plus one ticks.
// - On reaching zero, set interrupt status and reload from load register.
// - Any write to offset 0x0C clears status and reloads the counter.
// - Zero reached again with status set asserts reboot when enabled.
// - Control register at 0x08 enables interrupt and reboot separately.
// - Interrupt disabled halts counter; enabling restarts from load value.
// - Key 0x1ACC_E551 at 0xC00 unlocks writes; other values lock them.
// - Load register at 0x00 is read/write, resets to 0xFFFFFFF.
// - Count register at 0x04 is read-only, resets to 0xFFFFFFF.
// - Raw status at 0x10 shows interrupt state regardless of enables.
// - Masked status at 0x14 is raw status gated by interrupt enable.
// - Control bit 0 enables interrupt, bit 1 reboot; both reset low.
// - Writing the load register restarts counting from the new value.
// - Any value written to clear register clears; reads return zero.
// - Lock register reads 1 while locked, 0 while unlocked.
//
// The plain strobed port is this design's own decision.
module swdt_top (
	input  wire logic        mclk,      // 25 MHz clock
	input  wire logic        resetn,    // Synchronous reset, active low
	input  wire logic [11:0] addr,      // Register byte address
	input  wire logic [31:0] wdata,     // Write data
	input  wire logic        wr,        // Write strobe
	input  wire logic        rd,        // Read strobe
	output logic      [31:0] rdata,     // Read data, cycle after rd
	output logic             irq,       // Level interrupt
	output logic             reboot     // System reset request, level
);

	swdt_pkg::swdt_state_s q, d;
	swdt_pkg::swdt_req_s   req;
	logic                  tick;
	logic                  at_zero;
	logic                  wr_ok;
	logic                  irq_pend;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction : hit

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	always_comb begin
		d = q;
		// Single clock: the tick is a divider, so bus and count never cross domains
		tick = (q.div == swdt_pkg::TICK_CYCLES - 10'h001);
		at_zero = (q.count == 32'h0000_0000);
		wr_ok = req.wr && !q.locked;
		d.div = tick ? swdt_pkg::TICK_DIV_RESET : q.div + 10'h001;

		if (q.mode == swdt_pkg::WD_RUN && tick) begin
			if (at_zero) begin
				d.count = q.load;
				d.raw_irq = 1'b1;
				if (q.raw_irq && q.reboot_en) begin
					d.reboot = 1'b1;
				end
			end else begin
				d.count = q.count - 32'h0000_0001;
			end
		end

		// Bus writes come last so their reload wins over a same-cycle tick
		if (req.wr && hit(req.addr, swdt_pkg::ADDR_PROTECT)) begin
			d.locked = (req.wdata != swdt_pkg::UNLOCK_KEY);
		end
		if (wr_ok) begin
			unique case (req.addr)
				swdt_pkg::ADDR_LOAD: begin
					d.load = req.wdata;
					d.count = req.wdata;
				end
				swdt_pkg::ADDR_CONTROL: begin
					d.irq_en = req.wdata[swdt_pkg::IRQ_EN_BIT];
					d.reboot_en = req.wdata[swdt_pkg::REBOOT_EN_BIT];
					if (req.wdata[swdt_pkg::IRQ_EN_BIT] && !q.irq_en) begin
						d.count = q.load;
					end
				end
				swdt_pkg::ADDR_IRQ_CLEAR: begin
					d.raw_irq = 1'b0;
					d.count = q.load;
					// A clear that meets the second zero still counts as served
					d.reboot = q.reboot;
				end
				swdt_pkg::ADDR_IRQ_MASK: begin
					d.irq_mask = req.wdata[0];
				end
				default: begin
				end
			endcase
		end
		d.mode = d.irq_en ? swdt_pkg::WD_RUN : swdt_pkg::WD_IDLE;

		d.rdata = 32'h0000_0000;
		if (req.rd) begin
			unique case (req.addr)
				swdt_pkg::ADDR_LOAD:      d.rdata = q.load;
				swdt_pkg::ADDR_COUNT:     d.rdata = q.count;
				swdt_pkg::ADDR_CONTROL:   d.rdata = {30'h0, q.reboot_en, q.irq_en};
				swdt_pkg::ADDR_RAW_STAT:  d.rdata = {31'h0, q.raw_irq};
				swdt_pkg::ADDR_MASK_STAT: d.rdata = {31'h0, q.raw_irq & q.irq_en};
				swdt_pkg::ADDR_PROTECT:   d.rdata = {31'h0, q.locked};
				swdt_pkg::ADDR_IRQ_MASK:  d.rdata = {31'h0, q.irq_mask};
				default:                  d.rdata = 32'h0000_0000;
			endcase
		end
		irq_pend = d.raw_irq & d.irq_en & d.irq_mask;
		d.irq = irq_pend;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			q.mode      <= swdt_pkg::WD_IDLE;
			q.load      <= swdt_pkg::LOAD_RESET;
			q.count     <= swdt_pkg::LOAD_RESET;
			q.irq_en    <= 1'b0;
			q.reboot_en <= 1'b0;
			q.irq_mask  <= 1'b1;
			q.raw_irq   <= 1'b0;
			q.locked    <= 1'b0;
			q.div       <= swdt_pkg::TICK_DIV_RESET;
			q.rdata     <= 32'h0000_0000;
			q.irq       <= 1'b0;
			q.reboot    <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign rdata  = q.rdata;
	assign irq    = q.irq;
	assign reboot = q.reboot;

	// Counting and reload checks

	// Reboot only on a second zero with status still set
	reboot_cause_a: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(q.reboot) |-> $past(q.raw_irq) && $past(q.reboot_en) && $past(at_zero))
		else $error("reboot without pending irq");

	// Locked bus must not move the load value
	lock_write_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.locked && wr && addr == swdt_pkg::ADDR_LOAD) |=> $stable(q.load))
		else $error("load changed while locked");

	// Clear drops status and restarts the period
	clear_reload_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.locked && wr && addr == swdt_pkg::ADDR_IRQ_CLEAR) |=> !q.raw_irq && q.count == q.load)
		else $error("clear did not reload");

	// Disabled interrupt freezes the count
	halt_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.irq_en && !wr) |=> $stable(q.count))
		else $error("counter moved while disabled");

	// Zero sets status and reloads
	zero_reload_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.mode == swdt_pkg::WD_RUN && tick && at_zero && !wr) |=> q.raw_irq && q.count == q.load)
		else $error("zero did not reload");

	// One step down per tick
	tick_step_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.mode == swdt_pkg::WD_RUN && tick && !at_zero && !wr) |=> q.count == $past(q.count) - 1)
		else $error("count step wrong");

	// Count moves only on a tick or a write
	count_still_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!tick && !wr) |=> $stable(q.count))
		else $error("count moved without tick");

	// Divider wraps after its last cycle
	div_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
		tick |=> q.div == swdt_pkg::TICK_DIV_RESET)
		else $error("divider did not wrap");

	// Divider steps by one between ticks
	div_step_a: assert property (@(posedge mclk) disable iff (!resetn)
		!tick |=> q.div == $past(q.div) + 10'h001)
		else $error("divider step wrong");

	// Divider never leaves its range
	div_range_a: assert property (@(posedge mclk) disable iff (!resetn)
		q.div < swdt_pkg::TICK_CYCLES)
		else $error("divider out of range");

	// Ticks are single pulses
	tick_gap_a: assert property (@(posedge mclk) disable iff (!resetn)
		tick |=> !tick)
		else $error("tick lasted two cycles");

	// Status rises only at a zero while running
	raw_rise_a: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(q.raw_irq) |-> $past(tick) && $past(at_zero) && $past(q.mode) == swdt_pkg::WD_RUN)
		else $error("status set without zero");

	// Status holds until an accepted clear
	raw_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.raw_irq && !(wr && !q.locked && addr == swdt_pkg::ADDR_IRQ_CLEAR)) |=> q.raw_irq)
		else $error("status lost without clear");

	// Clear also drops the interrupt line
	clear_line_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.locked && wr && addr == swdt_pkg::ADDR_IRQ_CLEAR) |=> !irq)
		else $error("irq stayed after clear");

	// Reboot checks

	// Reboot is sticky until reset
	reboot_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
		q.reboot |=> q.reboot)
		else $error("reboot dropped");

	// No reboot while reboot generation is off
	reboot_off_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.reboot_en && !q.reboot) |=> !q.reboot)
		else $error("reboot while disabled");

	// First zero only raises the interrupt
	reboot_first_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.mode == swdt_pkg::WD_RUN && tick && at_zero && !q.raw_irq && !q.reboot) |=> !q.reboot)
		else $error("reboot on first zero");

	// Second zero with status set reboots
	reboot_second_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.mode == swdt_pkg::WD_RUN && tick && at_zero && q.raw_irq && q.reboot_en && !wr)
		|=> q.reboot)
		else $error("no reboot on second zero");

	// Control and write-lock checks

	// Control bits land as written
	ctrl_write_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.locked && wr && addr == swdt_pkg::ADDR_CONTROL)
		|=> q.irq_en == $past(wdata[swdt_pkg::IRQ_EN_BIT])
		&& q.reboot_en == $past(wdata[swdt_pkg::REBOOT_EN_BIT]))
		else $error("control write lost");

	// Control bits hold without a write
	ctrl_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		!(wr && addr == swdt_pkg::ADDR_CONTROL) |=> $stable(q.irq_en) && $stable(q.reboot_en))
		else $error("control changed by itself");

	// Enabling restarts from the load value
	enable_reload_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.locked && wr && addr == swdt_pkg::ADDR_CONTROL && wdata[swdt_pkg::IRQ_EN_BIT]
		&& !q.irq_en) |=> q.count == q.load)
		else $error("enable did not reload");

	// Disabling the interrupt stops the counter
	enable_off_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.locked && wr && addr == swdt_pkg::ADDR_CONTROL && !wdata[swdt_pkg::IRQ_EN_BIT])
		|=> q.mode == swdt_pkg::WD_IDLE)
		else $error("counter still running");

	// Run mode mirrors the interrupt enable
	mode_match_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.mode == swdt_pkg::WD_RUN) == q.irq_en)
		else $error("mode out of step");

	// Load write restarts the count
	load_write_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.locked && wr && addr == swdt_pkg::ADDR_LOAD)
		|=> q.load == $past(wdata) && q.count == $past(wdata))
		else $error("load write lost");

	// Load holds without a write
	load_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		!(wr && addr == swdt_pkg::ADDR_LOAD) |=> $stable(q.load))
		else $error("load changed by itself");

	// Count register ignores writes
	count_ro_a: assert property (@(posedge mclk) disable iff (!resetn)
		(wr && addr == swdt_pkg::ADDR_COUNT && !q.irq_en) |=> $stable(q.count))
		else $error("count written");

	// Mask bit lands as written
	mask_write_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.locked && wr && addr == swdt_pkg::ADDR_IRQ_MASK) |=> q.irq_mask == $past(wdata[0]))
		else $error("mask write lost");

	// Key opens the bank
	lock_key_a: assert property (@(posedge mclk) disable iff (!resetn)
		(wr && addr == swdt_pkg::ADDR_PROTECT && wdata == swdt_pkg::UNLOCK_KEY) |=> !q.locked)
		else $error("key did not unlock");

	// Any other value closes it
	lock_other_a: assert property (@(posedge mclk) disable iff (!resetn)
		(wr && addr == swdt_pkg::ADDR_PROTECT && wdata != swdt_pkg::UNLOCK_KEY) |=> q.locked)
		else $error("bad key did not lock");

	// Lock holds until the next lock write
	lock_stay_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.locked && !(wr && addr == swdt_pkg::ADDR_PROTECT)) |=> q.locked)
		else $error("lock dropped");

	// Unlocked holds until the next lock write
	unlock_stay_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!q.locked && !(wr && addr == swdt_pkg::ADDR_PROTECT)) |=> !q.locked)
		else $error("lock raised by itself");

	// Locked bus must not touch control
	lock_ctrl_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.locked && wr && addr == swdt_pkg::ADDR_CONTROL)
		|=> $stable(q.irq_en) && $stable(q.reboot_en))
		else $error("control changed while locked");

	// Locked load write must not restart the count
	lock_count_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.locked && wr && addr == swdt_pkg::ADDR_LOAD && !tick) |=> $stable(q.count))
		else $error("count restarted while locked");

	// Locked bus must not touch the mask
	lock_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
		(q.locked && wr && addr == swdt_pkg::ADDR_IRQ_MASK) |=> $stable(q.irq_mask))
		else $error("mask changed while locked");

	// Read port checks

	// Lock status reads back
	lock_read_a: assert property (@(posedge mclk) disable iff (!resetn)
		(rd && addr == swdt_pkg::ADDR_PROTECT) |=> rdata == {31'h0, $past(q.locked)})
		else $error("lock status read wrong");

	// Masked status is raw and enable
	mask_read_a: assert property (@(posedge mclk) disable iff (!resetn)
		(rd && addr == swdt_pkg::ADDR_MASK_STAT) |=> rdata[0] == ($past(q.raw_irq) & $past(q.irq_en)))
		else $error("masked status wrong");

	// Raw status ignores the enables
	raw_read_a: assert property (@(posedge mclk) disable iff (!resetn)
		(rd && addr == swdt_pkg::ADDR_RAW_STAT) |=> rdata == {31'h0, $past(q.raw_irq)})
		else $error("raw status read wrong");

	// Count reads back live
	count_read_a: assert property (@(posedge mclk) disable iff (!resetn)
		(rd && addr == swdt_pkg::ADDR_COUNT) |=> rdata == $past(q.count))
		else $error("count read wrong");

	// Load reads back
	load_read_a: assert property (@(posedge mclk) disable iff (!resetn)
		(rd && addr == swdt_pkg::ADDR_LOAD) |=> rdata == $past(q.load))
		else $error("load read wrong");

	// Control reads back its two bits
	ctrl_read_a: assert property (@(posedge mclk) disable iff (!resetn)
		(rd && addr == swdt_pkg::ADDR_CONTROL)
		|=> rdata == {30'h0, $past(q.reboot_en), $past(q.irq_en)})
		else $error("control read wrong");

	// Clear register reads zero
	clear_read_a: assert property (@(posedge mclk) disable iff (!resetn)
		(rd && addr == swdt_pkg::ADDR_IRQ_CLEAR) |=> rdata == 32'h0000_0000)
		else $error("clear register read not zero");

	// Read data stand only after a read
	idle_read_a: assert property (@(posedge mclk) disable iff (!resetn)
		!rd |=> rdata == 32'h0000_0000)
		else $error("read data without read");

	// Interrupt line follows unmasked status
	irq_match_a: assert property (@(posedge mclk) disable iff (!resetn)
		irq == (q.raw_irq && q.irq_en && q.irq_mask))
		else $error("irq line out of step");

endmodule : swdt_top

// ==== sim/test_swdt_top.sv ====
// Self-checking bench for the system watchdog timer
module test_swdt_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int T = swdt_pkg::TICK_CYCLES;
	logic        mclk    = 1'b0;
	logic        resetn  = 1'b0;
	logic [11:0] addr    = 12'h000;
	logic [31:0] wdata   = 32'h0;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic        rd_late = 1'b0;
	logic [31:0] rdata;
	logic        irq;
	logic        reboot;
	logic [31:0] exp_q[$];
	logic [31:0] v;
	int          n_mismatch = 0;
	int          n_tests    = 0;
	int          cyc        = 0;
	int          n;

	swdt_top dut (
		.mclk   (mclk),
		.resetn (resetn),
		.addr   (addr),
		.wdata  (wdata),
		.wr     (wr),
		.rd     (rd),
		.rdata  (rdata),
		.irq    (irq),
		.reboot (reboot)
	);

	initial begin
		forever #20 mclk = ~mclk;
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task tally_and_finish;
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	task wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [11:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge mclk);
		rd   <= 1'b0;
	endtask : rd_reg

	// Bounded wait; n returns the cycles spent
	task wait_hi(input bit on_reboot);
		n = 0;
		while (((on_reboot ? reboot : irq) !== 1'b1) && n < 5 * T) begin
			@(posedge mclk);
			n++;
		end
	endtask : wait_hi

	// Judged mid-cycle, clear of the edge that updates rdata
	always @(posedge mclk) rd_late <= rd;
	always @(negedge mclk) begin
		if (rd_late) check("rdata", rdata, exp_q.pop_front());
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		v = $urandom(58);
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		rd_reg(swdt_pkg::ADDR_LOAD, swdt_pkg::LOAD_RESET);
		rd_reg(swdt_pkg::ADDR_COUNT, swdt_pkg::LOAD_RESET);
		rd_reg(swdt_pkg::ADDR_CONTROL, 32'h0);
		rd_reg(swdt_pkg::ADDR_IRQ_CLEAR, 32'h0);
		rd_reg(swdt_pkg::ADDR_RAW_STAT, 32'h0);
		rd_reg(swdt_pkg::ADDR_MASK_STAT, 32'h0);
		rd_reg(swdt_pkg::ADDR_PROTECT, 32'h0);
		rd_reg(12'h020, 32'h0);
		v = $urandom;
		wr_reg(swdt_pkg::ADDR_COUNT, ~v);
		rd_reg(swdt_pkg::ADDR_COUNT, swdt_pkg::LOAD_RESET);
		wr_reg(swdt_pkg::ADDR_LOAD, v);
		rd_reg(swdt_pkg::ADDR_COUNT, v);
		wr_reg(swdt_pkg::ADDR_PROTECT, swdt_pkg::UNLOCK_KEY ^ (v | 32'h1));
		rd_reg(swdt_pkg::ADDR_PROTECT, 32'h1);
		wr_reg(swdt_pkg::ADDR_LOAD, 32'h2);
		rd_reg(swdt_pkg::ADDR_LOAD, v);
		wr_reg(swdt_pkg::ADDR_PROTECT, swdt_pkg::UNLOCK_KEY);
		rd_reg(swdt_pkg::ADDR_PROTECT, 32'h0);
		// Load 2 gives three ticks; first tick phase is unknown
		wr_reg(swdt_pkg::ADDR_LOAD, 32'h2);
		wr_reg(swdt_pkg::ADDR_CONTROL, 32'h1);
		wait_hi(1'b0);
		check("irq delay", 32'(n > 2 * T && n <= 3 * T + 4), 32'h1);
		rd_reg(swdt_pkg::ADDR_RAW_STAT, 32'h1);
		rd_reg(swdt_pkg::ADDR_MASK_STAT, 32'h1);
		wr_reg(swdt_pkg::ADDR_IRQ_MASK, 32'h0);
		repeat (2) @(posedge mclk);
		check("irq masked", 32'(irq), 32'h0);
		rd_reg(swdt_pkg::ADDR_RAW_STAT, 32'h1);
		wr_reg(swdt_pkg::ADDR_IRQ_MASK, 32'h1);
		// One more zero with status set, reboot still disabled
		repeat (4 * T) @(posedge mclk);
		check("reboot off", 32'(reboot), 32'h0);
		wr_reg(swdt_pkg::ADDR_IRQ_CLEAR, $urandom);
		repeat (2) @(posedge mclk);
		check("irq cleared", 32'(irq), 32'h0);
		rd_reg(swdt_pkg::ADDR_RAW_STAT, 32'h0);
		wr_reg(swdt_pkg::ADDR_CONTROL, 32'h3);
		wait_hi(1'b0);
		wait_hi(1'b1);
		check("reboot delay", 32'(n > 2 * T && n <= 3 * T + 4), 32'h1);
		tally_and_finish();
	end
endmodule : test_swdt_top
